// ### hw/tdop_pkg.sv
// Shared constants, word layouts and states of the threshold detector port
package tdop_pkg;
  // Data widths and storage depths
  localparam int MAG_W = 16;
  localparam int RNG_W = 10;
  localparam int AZ_W = 12;
  localparam int PRF_W = 2;
  localparam int DLY_DEPTH = 64;
  localparam int Q_DEPTH = 40;
  localparam int MAX_HITS = 38;
  localparam logic [5:0] Q_FULL = 6'(Q_DEPTH);
  localparam logic [5:0] Q_LAST = 6'(Q_DEPTH - 1);
  localparam logic [5:0] DWELL_CAP = 6'(MAX_HITS + 1);
  localparam logic [2:0] FILT_LAST = 3'h7;
  localparam logic [2:0] FILT_ONE = 3'h1;
  // Word shift pace: 1.3 MHz period in ps over the 5 ns clock
  localparam int CLK_PS = 5000;
  localparam int SHIFT_PS = 769231;
  localparam int SHIFT_CYC = SHIFT_PS / CLK_PS;
  localparam logic [7:0] SHIFT_LAST = 8'(SHIFT_CYC - 1);
  // Clutter attenuation codes and the matching right shifts
  localparam logic [1:0] ATT_30DB = 2'h0;
  localparam logic [1:0] ATT_36DB = 2'h1;
  localparam logic [1:0] ATT_42DB = 2'h2;
  localparam int SH_30DB = 5;
  localparam int SH_36DB = 6;
  localparam int SH_42DB = 7;
  // Register map, field positions and reset values
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_ATT_LSB = 0;
  localparam int CTRL_SRC_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Dwell header word
  typedef struct packed {
    logic mark;
    logic [13:0] spare;
    logic [AZ_W-1:0] az;
    logic [PRF_W-1:0] prf;
    logic lost_data;
    logic lost_hits;
    logic spare0;
  } tdop_hdr_t;
  // Detection word
  typedef struct packed {
    logic mark;
    logic [1:0] spare;
    logic [MAG_W-1:0] strength;
    logic [RNG_W-1:0] range;
    logic [2:0] vel;
  } tdop_det_t;
  // Output port sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_REQ = 2'b10,
    ST_WAIT = 2'b11
  } tdop_st_t;
endpackage

// ### hw/tdop_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module tdop_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ### hw/tdop_axil.sv
// AXI4-Lite slave holding the control and status registers
`timescale 1ns/1ps
module tdop_axil (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] stat_word,
  output logic [2:0] ctrl_r
);
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;

  // Decode of the held write and of the read address
  wire wr_go = aw_hold_r & w_hold_r & ~bvalid;
  wire wr_ctrl = aw_addr_r == tdop_pkg::REG_CTRL;
  wire wr_ok = wr_ctrl | (aw_addr_r == tdop_pkg::REG_STAT);
  wire rd_ctrl = araddr == tdop_pkg::REG_CTRL;
  wire rd_stat = araddr == tdop_pkg::REG_STAT;
  wire [31:0] rd_word = rd_ctrl ? {29'h0, ctrl_r} :
                        rd_stat ? stat_word : 32'h0;

  // Address and data are taken in either order, answered once both held
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r <= 8'h0;
      w_lane0_r <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= tdop_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= wdata[7:0];
        w_lane0_r <= wstrb[0];
        wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? tdop_pkg::RESP_OKAY : tdop_pkg::RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Only byte lane 0 carries control bits; status writes are ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= tdop_pkg::CTRL_RST;
    end else if (wr_go && wr_ctrl && w_lane0_r) begin
      ctrl_r <= w_data_r[2:0];
    end
  end

  // One read at a time, answered the cycle after the address is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= tdop_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= (rd_ctrl | rd_stat) ? tdop_pkg::RESP_OKAY :
               tdop_pkg::RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// ### hw/tdop_top.sv
// Threshold detectors and dwell output port, top level
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module tdop_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_MAG,
  input wire logic [15:0] CLUTTER_TH,
  input wire logic [15:0] WEATHER_TH,
  input wire logic GATE_SAT,
  input wire logic GATE_INTF,
  input wire logic DWELL_START,
  input wire logic DWELL_END,
  input wire logic [1:0] PRF_IND,
  input wire logic [11:0] AZIMUTH,
  output logic [15:0] DELAYED_MAG,
  output logic DELAYED_VALID,
  output logic DETECTION_STROBE,
  output logic [31:0] OUT_DATA,
  output logic WORD_REQUEST,
  input wire logic ACK_PROC,
  input wire logic ACK_MON
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic gt(input logic [15:0] a, input logic [15:0] b);
    return a > b;
  endfunction

  function automatic logic [15:0] atten(input logic [15:0] c,
                                        input logic [1:0] sel);
    logic [15:0] r;
    r = c >> tdop_pkg::SH_30DB;
    if (sel == tdop_pkg::ATT_36DB) begin
      r = c >> tdop_pkg::SH_36DB;
    end else if (sel == tdop_pkg::ATT_42DB) begin
      r = c >> tdop_pkg::SH_42DB;
    end
    return r;
  endfunction

  function automatic logic [5:0] inc_idx(input logic [5:0] i);
    return (i == tdop_pkg::Q_LAST) ? 6'h0 : 6'(i + 6'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register slave
  logic [2:0] ctrl_r;
  logic [31:0] stat_w;
  logic lost_hits_r;
  logic lost_data_r;
  logic [5:0] fill_n_r;
  logic [5:0] out_n_r;
  tdop_pkg::tdop_st_t st_r;

  // Status shows queue fill, output fill, state and pending loss flags
  assign stat_w = {16'h0, out_n_r, fill_n_r, st_r, lost_data_r,
                   lost_hits_r};

  tdop_axil u_axil (
    .clk(CLK),
    .nrst(NRST),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .stat_word(stat_w),
    .ctrl_r(ctrl_r)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Magnitude delay line
  logic [15:0] dly_r [tdop_pkg::DLY_DEPTH];
  wire [15:0] dmag = dly_r[tdop_pkg::DLY_DEPTH-1];

  // Shifts once per filter sample, so 64 samples span eight gates
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < tdop_pkg::DLY_DEPTH; i++) begin
        dly_r[i] <= 16'h0;
      end
    end else if (SAMPLE_VALID) begin
      dly_r[0] <= SAMPLE_MAG;
      for (int i = 1; i < tdop_pkg::DLY_DEPTH; i++) begin
        dly_r[i] <= dly_r[i-1];
      end
    end
  end

  // Delayed stream feeds the external threshold generators
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DELAYED_MAG <= 16'h0;
      DELAYED_VALID <= 1'b0;
    end else begin
      DELAYED_MAG <= dmag;
      DELAYED_VALID <= SAMPLE_VALID;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter and range counters, per-gate latches
  logic [2:0] filt_r;
  logic [9:0] range_r;
  logic [15:0] clut_g_r;
  logic inh_r;
  wire f0 = filt_r == 3'h0;
  wire gate_end = SAMPLE_VALID & (filt_r == tdop_pkg::FILT_LAST);

  // Counters restart at dwell start; range steps after filter seven
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      filt_r <= 3'h0;
      range_r <= 10'h0;
    end else if (DWELL_START) begin
      filt_r <= 3'h0;
      range_r <= 10'h0;
    end else if (SAMPLE_VALID) begin
      filt_r <= 3'(filt_r + 3'h1);
      range_r <= gate_end ? 10'(range_r + 10'h1) : range_r;
    end
  end

  // Clutter level and gate inhibit are held from filter zero
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      clut_g_r <= 16'h0;
      inh_r <= 1'b0;
    end else if (SAMPLE_VALID && f0) begin
      clut_g_r <= CLUTTER_TH;
      inh_r <= GATE_SAT | GATE_INTF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparators
  logic cmp_zvf;
  logic cmp_wx;
  logic cmp_att;
  logic inh;
  logic hit_nxt;
  wire is17 = (filt_r == tdop_pkg::FILT_ONE) |
              (filt_r == tdop_pkg::FILT_LAST);
  wire [15:0] clut_att = atten(clut_g_r, ctrl_r[1:0]);

  // Forcing terms make each comparator neutral outside its filters
  assign cmp_zvf = ~f0 | gt(dmag, CLUTTER_TH);
  assign cmp_wx = f0 | gt(dmag, WEATHER_TH);
  assign cmp_att = ~is17 | gt(dmag, clut_att);
  assign inh = f0 ? (GATE_SAT | GATE_INTF) : inh_r;
  assign hit_nxt = SAMPLE_VALID & cmp_zvf & cmp_wx & cmp_att & ~inh;

  tdop_pkg::tdop_det_t det_w;
  tdop_pkg::tdop_det_t det_r;
  assign det_w = '{mark: 1'b0, spare: 2'h0, strength: dmag,
                   range: range_r, vel: filt_r};

  // Strobe and its captured word, one cycle after the compare
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DETECTION_STROBE <= 1'b0;
      det_r <= '0;
    end else begin
      DETECTION_STROBE <= hit_nxt;
      det_r <= hit_nxt ? det_w : det_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input queue, one dwell being filled
  logic [31:0] fill_r [tdop_pkg::Q_DEPTH];
  logic [5:0] fill_wp_r;
  logic [5:0] fill_rp_r;
  logic [5:0] dwell_n_r;
  logic [5:0] move_left_r;
  logic [7:0] tick_r;
  tdop_pkg::tdop_hdr_t hdr_w;

  wire fill_full = fill_n_r == tdop_pkg::Q_FULL;
  wire wr_hdr = DWELL_START & ~fill_full;
  wire wr_det = DETECTION_STROBE & ~DWELL_START & ~fill_full &
                (dwell_n_r < tdop_pkg::DWELL_CAP);
  wire lost_hit_ev = DETECTION_STROBE & ~wr_det;
  wire fill_we = wr_hdr | wr_det;
  wire tick = tick_r == tdop_pkg::SHIFT_LAST;
  wire move_rd = (st_r == tdop_pkg::ST_MOVE) & tick &
                 (move_left_r != 6'h0) & (fill_n_r != 6'h0);
  wire out_busy = (out_n_r != 6'h0) | (st_r != tdop_pkg::ST_IDLE);
  wire lost_data_ev = DWELL_END & out_busy;

  // Header carries the loss flags gathered during the previous dwell
  assign hdr_w = '{mark: 1'b1, spare: 14'h0, az: AZIMUTH, prf: PRF_IND,
                   lost_data: lost_data_r | lost_data_ev,
                   lost_hits: lost_hits_r | lost_hit_ev,
                   spare0: 1'b0};

  // A new word is written at the write index; earlier words stay where they are
  always_ff @(posedge CLK) begin
    if (fill_we) begin
      fill_r[fill_wp_r] <= wr_hdr ? hdr_w : det_r;
    end
  end

  // Filling goes on while the previous dwell moves out
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fill_wp_r <= 6'h0;
      fill_rp_r <= 6'h0;
      fill_n_r <= 6'h0;
    end else begin
      fill_wp_r <= fill_we ? inc_idx(fill_wp_r) : fill_wp_r;
      fill_rp_r <= move_rd ? inc_idx(fill_rp_r) : fill_rp_r;
      fill_n_r <= 6'(fill_n_r + {5'h0, fill_we} - {5'h0, move_rd});
    end
  end

  // Words counted per dwell; a concurrent hit loses to the header
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dwell_n_r <= 6'h0;
    end else if (wr_hdr) begin
      dwell_n_r <= 6'h1;
    end else if (DWELL_END) begin
      dwell_n_r <= 6'h0;
    end else if (wr_det) begin
      dwell_n_r <= 6'(dwell_n_r + 6'h1);
    end
  end

  // Loss flags: the clear at dwell start beats a fresh event in the same cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lost_hits_r <= 1'b0;
      lost_data_r <= 1'b0;
    end else begin
      lost_hits_r <= (lost_hits_r & ~DWELL_START) |
                     (lost_hit_ev & ~DWELL_START);
      lost_data_r <= (lost_data_r & ~DWELL_START) |
                     (lost_data_ev & ~DWELL_START);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output register and request sequencer
  logic [31:0] out_r [tdop_pkg::Q_DEPTH];
  logic [5:0] out_wp_r;
  logic [5:0] out_rp_r;
  logic [1:0] ack_s;
  logic ack_prev_r;
  tdop_pkg::tdop_st_t st_nxt;

  tdop_sync #(.W(2)) u_ack_sync (
    .clk(CLK),
    .nrst(NRST),
    .d({ACK_MON, ACK_PROC}),
    .q(ack_s)
  );

  // Source select; switching sources may look like one acknowledge
  wire ack_sel = ctrl_r[tdop_pkg::CTRL_SRC_BIT] ? ack_s[1] : ack_s[0];
  wire ack_edge = ack_sel & ~ack_prev_r;
  wire ack_take = (st_r == tdop_pkg::ST_WAIT) & ack_edge;
  wire move_done = (st_r == tdop_pkg::ST_MOVE) & (move_left_r == 6'h0);

  // Next state; a dwell end always restarts the move
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      tdop_pkg::ST_IDLE: st_nxt = tdop_pkg::ST_IDLE;
      tdop_pkg::ST_MOVE: begin
        if (move_done) begin
          st_nxt = (out_n_r != 6'h0) ? tdop_pkg::ST_REQ :
                   tdop_pkg::ST_IDLE;
        end
      end
      tdop_pkg::ST_REQ: st_nxt = tdop_pkg::ST_WAIT;
      tdop_pkg::ST_WAIT: begin
        if (ack_take) begin
          st_nxt = (out_n_r == 6'h1) ? tdop_pkg::ST_IDLE :
                   tdop_pkg::ST_REQ;
        end
      end
    endcase
    if (DWELL_END) begin
      st_nxt = tdop_pkg::ST_MOVE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= tdop_pkg::ST_IDLE;
      ack_prev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ack_prev_r <= ack_sel;
    end
  end

  // Pace counter for the 1.3 MHz word shift
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tick_r <= 8'h0;
    end else if (DWELL_END || tick) begin
      tick_r <= 8'h0;
    end else begin
      tick_r <= 8'(tick_r + 8'h1);
    end
  end

  // Words moved in order, header first, one per pace tick
  always_ff @(posedge CLK) begin
    if (move_rd) begin
      out_r[out_wp_r] <= fill_r[fill_rp_r];
    end
  end

  // A dwell end drops whatever the output register still holds
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      move_left_r <= 6'h0;
      out_wp_r <= 6'h0;
      out_rp_r <= 6'h0;
      out_n_r <= 6'h0;
    end else if (DWELL_END) begin
      move_left_r <= 6'(move_left_r + dwell_n_r);
      out_wp_r <= 6'h0;
      out_rp_r <= 6'h0;
      out_n_r <= 6'h0;
    end else begin
      move_left_r <= move_rd ? 6'(move_left_r - 6'h1) : move_left_r;
      out_wp_r <= move_rd ? inc_idx(out_wp_r) : out_wp_r;
      out_rp_r <= ack_take ? inc_idx(out_rp_r) : out_rp_r;
      out_n_r <= 6'(out_n_r + {5'h0, move_rd} - {5'h0, ack_take});
    end
  end

  // Word loads with its request and then holds until acknowledged
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      OUT_DATA <= 32'h0;
      WORD_REQUEST <= 1'b0;
    end else begin
      WORD_REQUEST <= st_r == tdop_pkg::ST_REQ;
      if (st_r == tdop_pkg::ST_REQ) begin
        OUT_DATA <= out_r[out_rp_r];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_zvf_forced: assert property (SAMPLE_VALID && !f0 |-> cmp_zvf)
    else $error("clutter compare not forced");
  a_wx_forced: assert property (SAMPLE_VALID && f0 |-> cmp_wx)
    else $error("weather compare not forced");
  a_att_forced: assert property (!is17 |-> cmp_att)
    else $error("attenuated compare not forced");
  a_gate_inhibit: assert property (
    SAMPLE_VALID && inh |=> !DETECTION_STROBE)
    else $error("strobe in inhibited gate");
  a_strobe_cause: assert property (
    DETECTION_STROBE |-> $past(SAMPLE_VALID) && $past(cmp_zvf) &&
    $past(cmp_wx) && $past(cmp_att))
    else $error("strobe without all compares");
  a_hdr_first: assert property (
    wr_hdr |=> dwell_n_r == 6'h1 && fill_n_r != 6'h0)
    else $error("header not loaded");
  a_dwell_cap: assert property (dwell_n_r <= tdop_pkg::DWELL_CAP)
    else $error("dwell word cap exceeded");
  a_lost_data: assert property (
    lost_data_ev && !DWELL_START |=> lost_data_r && out_n_r == 6'h0)
    else $error("undrained output not flagged");
  a_req_pulse: assert property (
    WORD_REQUEST && st_r == tdop_pkg::ST_WAIT && !DWELL_END && !ack_take
    |=> !WORD_REQUEST ##0 st_r == tdop_pkg::ST_WAIT)
    else $error("request longer than one cycle");
  a_data_hold: assert property (
    st_r == tdop_pkg::ST_WAIT && !ack_take && !DWELL_END |=>
    $stable(OUT_DATA))
    else $error("output word changed before acknowledge");
  a_move_pace: assert property (
    move_rd |=> !move_rd [*8])
    else $error("words shifted too fast");

  c_hit: cover property (DETECTION_STROBE);
  c_word: cover property (WORD_REQUEST ##[1:200] ack_take);
  c_lost_hits: cover property (lost_hit_ev);
  c_lost_data: cover property (lost_data_ev);
endmodule

// ### tb/tdop_iop.sv
// Behavioural io processor that takes each offered word and acknowledges it
`timescale 1ns/1ps
module tdop_iop #(
  parameter int DLY = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic hold,
  output logic ack
);
  logic pend_r;
  logic [3:0] cnt_r;
  // Two-cycle acknowledge DLY + 1 cycles after a request is seen; hold stalls the reader
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= 1'h0;
      cnt_r <= 4'h0;
      ack <= 1'h0;
    end else if (req) begin
      pend_r <= 1'h1;
      cnt_r <= 4'h0;
      ack <= 1'h0;
    end else if (pend_r && !hold) begin
      cnt_r <= cnt_r + 4'h1;
      ack <= (cnt_r == 4'(DLY)) || (cnt_r == 4'(DLY + 1));
      pend_r <= cnt_r != 4'(DLY + 2); // Low again well before next request
    end
  end
endmodule

// ### tb/threshold_detect_output_port_test.sv
// Testbench for the threshold detectors and the dwell output port
`timescale 1ns/1ps
module threshold_detect_output_port_test;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic sv = 1'h0, sat = 1'h0, dst = 1'h0, den = 1'h0, hold = 1'h0;
  logic src = 1'h0;
  logic [15:0] mag = 16'h0100, cl = 16'h0000, wt = 16'h0000;
  logic [11:0] az = 12'h000;
  logic awr, wr, bv, arr, rv, dstb, wreq, ack, ackp, ackm, dv;
  logic [15:0] dmg;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, odata;
  logic [31:0] q[$];
  int nst = 0;
  int num_errors = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Design, reader and acknowledge steering
  tdop_top tdop_top_i (.CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .SAMPLE_VALID(sv), .SAMPLE_MAG(mag),
    .CLUTTER_TH(cl), .WEATHER_TH(wt), .GATE_SAT(sat), .GATE_INTF(1'h0),
    .DWELL_START(dst), .DWELL_END(den), .PRF_IND(2'h2), .AZIMUTH(az),
    .DELAYED_MAG(dmg), .DELAYED_VALID(dv), .DETECTION_STROBE(dstb),
    .OUT_DATA(odata), .WORD_REQUEST(wreq), .ACK_PROC(ackp),
    .ACK_MON(ackm));
  tdop_iop tdop_iop_i (.clk(clk), .nrst(nrst), .req(wreq), .hold(hold),
    .ack(ack));
  // Reset gating keeps the acknowledge lines defined from time zero
  assign ackp = !src && ack && nrst;
  assign ackm = src && ack && nrst;
  always #2.5 clk = ~clk;
  // Record each offered word; it must not move while being acknowledged
  always @(posedge clk) begin
    if (wreq === 1'h1) q.push_back(odata);
    if (dstb === 1'h1) nst++;
    if ((ackp | ackm) === 1'h1) chk("held", q[$], odata);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axw(logic [7:0] a, logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end while (!bv);
    br <= 1'h0;
    chk("bresp", 32'h0, 32'(bresp));
  endtask
  task automatic axr(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    araddr <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rr <= 1'h0;
    chk("rdata", d, rdata);
    chk("rresp", 32'(e), 32'(rresp));
  endtask
  // One range gate: eight filter samples, thresholds packed filter 0 lowest
  task automatic gate(logic [127:0] c, logic [127:0] w, logic s);
    for (int f = 0; f < 8; f++) begin
      sv <= 1'h1;
      cl <= c[f*16+:16];
      wt <= w[f*16+:16];
      sat <= s;
      @(posedge clk);
    end
  endtask
  task automatic ds(logic [11:0] a);
    az <= a;
    dst <= 1'h1;
    @(posedge clk);
    dst <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic de;
    den <= 1'h1;
    @(posedge clk);
    den <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // Word moves are slow, so the wait allows a full forty-word shift
  task automatic wq(int n);
    repeat (8000) if (q.size() < n) @(posedge clk);
    chk("words", 32'(n), 32'(q.size()));
  endtask
  function automatic logic [31:0] hdr(logic [11:0] a, logic ld, logic lh);
    return {1'h1, 14'h0000, a, 2'h2, ld, lh, 1'h0};
  endfunction
  function automatic logic [31:0] det(logic [9:0] r, logic [2:0] f);
    return {3'h0, 16'h0100, r, f};
  endfunction
  task automatic results;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    axr(8'h00, 32'h0, 2'h0);
    axr(8'h08, 32'h0, 2'h3);
    $display("Test registers done");
    // Prime the delay line; it leaves reset at zero, so the level must
    // show only once 64 samples have passed through it
    for (int g = 0; g < 8; g++) gate({8{16'hFFFF}}, {8{16'hFFFF}}, 1'h0);
    sv <= 1'h0;
    @(posedge clk);
    chk("dly_63", 32'h0, 32'(dmg));
    chk("dly_valid", 32'h1, 32'(dv));
    ds(12'h123);
    chk("dly_64", 32'h100, 32'(dmg));
    gate({16'h1FE0, {5{16'hFFFF}}, 16'h2000, 16'h00FF}, {16'h0000,
      {3{16'hFFFF}}, 16'h0100, 16'h00FF, 16'hFFFF, 16'hFFFF}, 1'h0);
    gate(128'h0, 128'h0, 1'h1);
    sv <= 1'h0;
    axw(8'h00, 32'h2);
    gate({8{16'h7F80}}, {{6{16'hFFFF}}, 16'h0000, 16'hFFFF}, 1'h0);
    sv <= 1'h0;
    chk("strobes", 32'h4, 32'(nst));
    de();
    ds(12'h456);
    wq(5);
    chk("hdr_a", hdr(12'h123, 1'h0, 1'h0), q[0]);
    chk("det_f0", det(10'h000, 3'h0), q[1]);
    chk("det_f2", det(10'h000, 3'h2), q[2]);
    chk("det_f7", det(10'h000, 3'h7), q[3]);
    chk("det_att", det(10'h002, 3'h1), q[4]);
    $display("Test detection done");
    repeat (30) @(posedge clk);
    hold <= 1'h1;
    de();
    wq(6);
    chk("hdr_b", hdr(12'h456, 1'h0, 1'h0), q[5]);
    axw(8'h00, 32'h6);
    src <= 1'h1;
    ds(12'h789);
    de();
    ds(12'hABC);
    hold <= 1'h0;
    repeat (5) gate(128'h0, 128'h0, 1'h0);
    sv <= 1'h0;
    de();
    wq(46);
    chk("hdr_c", hdr(12'h789, 1'h0, 1'h0), q[6]);
    chk("hdr_d", hdr(12'hABC, 1'h1, 1'h0), q[7]);
    chk("det_last", det(10'h004, 3'h5), q[45]);
    ds(12'hDEF);
    de();
    wq(47);
    chk("hdr_e", hdr(12'hDEF, 1'h1, 1'h1), q[46]);
    $display("Test output port done");
    results;
  end
  // Watchdog sized well beyond five dwells of slow word moves
  initial begin
    #400000;
    num_errors++;
    results;
  end
endmodule
